// ---- core/pixel_tx_mapper.sv ----
`include "pixel_tx_defines.svh"

// Operation
// - Dual select high takes both 12-bit ports and drives data lanes 0 to 7.
// - Balance off sends unbalanced format; port 1 on lanes 0-3, port 2 on 4-7.
// - Balance on sends DC-balanced words during active data, same lane split.
// - Lower half latched on primary edge, upper half on next opposite edge.
// - Differential clock mode samples the 24 inputs at clock crossings.
// - With polarity setting high, high data enable marks valid pixels.
// - Odd pixel colours come from inputs 0-11 of both edges as mapped.
// - Even pixel colours come from inputs 12-23 of both edges as mapped.
// - Balanced blanking sends data enable level on first clock lane patterns.
// - Balanced blanking sends horizontal sync on lane 0, vertical on lane 1.
// - Polarity setting low inverts data enable sense; blanking still sends the low patterns.
// - Single-pixel mode keeps lanes 4 to 7 and second clock lane off.
// - Lane bit positions 6,7 carry colour bits 0,1; 0-5 carry 2-7.
module pixel_tx_mapper #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pix_clk,
  input  wire logic [23:0]       half_pixel_inputs,
  input  wire logic              de_in,
  input  wire logic              hsync_in,
  input  wire logic              vsync_in,
  output logic [7:0][6:0]        serial_data_lanes,
  output logic [6:0]             first_clock_lane,
  output logic [6:0]             second_clock_lane,
  output logic [9:0]             lane_enable,
  output logic                   diff_clock_select
);
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
    $error("pixel_tx_mapper: ADDR_W must be 3 to 32");
  end

  function automatic logic [7:0] lvds_order(logic [7:0] c);
    return {c[1:0], c[7:2]};
  endfunction

  // Register bus, ref_clk domain
  logic                     aw_got_r;
  logic                     w_got_r;
  logic [ADDR_W-1:0]        waddr_r;
  logic [31:0]              wdata_r;
  logic [3:0]               wstrb_r;
  logic [`CTRL_W-1:0]       ctrl_r;
  logic [`STAT_W-1:0]       stat_s;

  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire b_hs     = s_axi_bvalid & s_axi_bready;
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire r_hs     = s_axi_rvalid & s_axi_rready;
  wire wr_go    = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wa_ctrl  = waddr_r == ADDR_W'(`CTRL_OFS);
  wire wa_stat  = waddr_r == ADDR_W'(`STAT_OFS);
  wire wr_ctrl  = wr_go & wa_ctrl & wstrb_r[0];
  wire ra_ctrl  = s_axi_araddr == ADDR_W'(`CTRL_OFS);
  wire ra_stat  = s_axi_araddr == ADDR_W'(`STAT_OFS);
  wire [31:0] rd_word =
    ra_ctrl ? {{(32-`CTRL_W){1'b0}}, ctrl_r} :
    ra_stat ? {{(32-`STAT_W){1'b0}}, stat_s} : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      aw_got_r      <= 1'b0;
      waddr_r       <= '0;
    end else if (aw_hs) begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b1;
      waddr_r       <= s_axi_awaddr;
    end else begin
      if (b_hs) s_axi_awready <= 1'b1;
      if (wr_go) aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      w_got_r      <= 1'b0;
      wdata_r      <= '0;
      wstrb_r      <= '0;
    end else if (w_hs) begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end else begin
      if (b_hs) s_axi_wready <= 1'b1;
      if (wr_go) w_got_r <= 1'b0;
    end
  end

  // Writes to the status word are accepted and dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pixel_tx_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wa_ctrl | wa_stat) ? pixel_tx_pkg::RESP_OKAY
                                          : pixel_tx_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_r[`CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pixel_tx_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (ra_ctrl | ra_stat) ? pixel_tx_pkg::RESP_OKAY
                                           : pixel_tx_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Clock receiver mode pin, straight from the control flop
  assign diff_clock_select = ctrl_r[`CLKSEL_BIT];

  // Link side, pix_clk domain
  logic [`CTRL_W-1:0]       ctrl_s;
  logic [`STAT_W-1:0]       stat_pix_r;
  logic [23:0]              lo_r;
  logic [23:0]              hi_r;
  logic [23:0]              pix_lo_r;
  logic [23:0]              pix_hi_r;
  logic [2:0]               ctl_lo_r;
  logic [2:0]               ctl_r;
  logic [1:0][7:0]          red;
  logic [1:0][7:0]          grn;
  logic [1:0][7:0]          blu;
  pixel_tx_pkg::lane_word_t raw_w [10];
  logic [5:0]               pay_w [10];
  logic [9:0][6:0]          lane_q;

  bit_sync #(
    .W   (`CTRL_W),
    .RST (`CTRL_RST)
  ) u_ctrl_sync (
    .clk    (pix_clk),
    .arst_n (arst_n),
    .d      (ctrl_r),
    .q      (ctrl_s)
  );

  bit_sync #(
    .W   (`STAT_W),
    .RST ('0)
  ) u_stat_sync (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .d      (stat_pix_r),
    .q      (stat_s)
  );
  wire dual_s    = ctrl_s[`DUAL_BIT];
  wire balance_s = ctrl_s[`BALANCE_BIT];
  wire pol_s     = ctrl_s[`POL_BIT];
  wire de        = ctl_r[0];
  wire hs        = ctl_r[1];
  wire vs        = ctl_r[2];
  wire act       = ~(de ^ pol_s);
  wire de_lvl    = de ^ ~pol_s;
  wire blank     = balance_s & ~act;

  // Either clock receiver hands us one edge pair per period
  always_ff @(posedge pix_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_r     <= '0;
      ctl_lo_r <= '0;
    end else begin
      lo_r     <= half_pixel_inputs;
      ctl_lo_r <= {vsync_in, hsync_in, de_in};
    end
  end

  always_ff @(negedge pix_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_r <= '0;
    end else begin
      hi_r <= half_pixel_inputs;
    end
  end

  // Lower half of period t meets the upper half that followed it
  always_ff @(posedge pix_clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_lo_r    <= '0;
      pix_hi_r    <= '0;
      ctl_r       <= '0;
      lane_enable <= '0;
      stat_pix_r  <= '0;
    end else begin
      pix_lo_r    <= lo_r;
      pix_hi_r    <= hi_r;
      ctl_r       <= ctl_lo_r;
      lane_enable <= {dual_s, 1'b1, {4{dual_s}}, 4'hf};
      stat_pix_r  <= {dual_s, vs, hs, act};
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int B = 12 * p;
    localparam int L = 4 * p;
    logic [7:0] rl;
    logic [7:0] gl;
    logic [7:0] bl;

    assign red[p] = pix_hi_r[B+4 +: 8];
    assign grn[p] = {pix_hi_r[B +: 4], pix_lo_r[B+8 +: 4]};
    assign blu[p] = pix_lo_r[B +: 8];
    assign rl     = lvds_order(red[p]);
    assign gl     = lvds_order(grn[p]);
    assign bl     = lvds_order(blu[p]);

    assign raw_w[L]   = {rl[0], rl[1], rl[2], rl[3], rl[4], rl[5],
                         gl[0]};
    assign raw_w[L+1] = {gl[1], gl[2], gl[3], gl[4], gl[5], bl[0],
                         bl[1]};
    assign raw_w[L+2] = {bl[2], bl[3], bl[4], bl[5], hs, vs, de};
    assign raw_w[L+3] = {rl[6], rl[7], gl[6], gl[7], bl[6], bl[7],
                         1'b0};
    assign pay_w[L]   = rl[5:0];
    assign pay_w[L+1] = gl[5:0];
    assign pay_w[L+2] = bl[5:0];
    assign pay_w[L+3] = {rl[7:6], gl[7:6], bl[7:6]};
  end
  assign raw_w[8] = `PAT_CLK;
  assign raw_w[9] = `PAT_CLK;
  assign pay_w[8] = '0;
  assign pay_w[9] = '0;

  // Lanes 0-7 data, 8 and 9 the forwarded clocks
  for (genvar i = 0; i < 10; i++) begin : g_lane
    localparam bit IS_CLK = (i >= 8);
    localparam bit ALWAYS = (i < 4) || (i == 8);
    wire lvl = (i == 0) ? hs : (i == 1) ? vs : IS_CLK ? de_lvl : 1'b0;
    wire [6:0] pat_p = IS_CLK ? (lvl ? `PAT_DEH_P : `PAT_DEL_P)
                              : (lvl ? `PAT_SYH_P : `PAT_SYL_P);
    wire [6:0] pat_n = IS_CLK ? (lvl ? `PAT_DEH_N : `PAT_DEL_N)
                              : (lvl ? `PAT_SYH_N : `PAT_SYL_N);
    wire       on    = ALWAYS | dual_s;
    // Clock lanes only leave the clock pattern for blanking codes
    wire       dc_on = IS_CLK ? blank : balance_s;
    lane_balancer u_lane (
      .clk      (pix_clk),
      .arst_n   (arst_n),
      .lane_on  (on),
      .dc_en    (dc_on),
      .ctl_mode (blank),
      .raw      (raw_w[i]),
      .pay      (pay_w[i]),
      .pat_p    (pat_p),
      .pat_n    (pat_n),
      .word_q   (lane_q[i])
    );
  end

  assign serial_data_lanes = lane_q[7:0];
  assign first_clock_lane  = lane_q[8];
  assign second_clock_lane = lane_q[9];
  dual_lanes_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    dual_s |=> lane_enable == 10'h3ff)
    else $error("dual mode did not enable all lanes");
  single_off_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    !dual_s |=> lane_q[4] == '0 && lane_q[7] == '0 && lane_q[9] == '0)
    else $error("upper lanes active in single mode");
  unbal_word_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    !balance_s |=> lane_q[2][0] == $past(de)
      && lane_q[0][6] == $past(red[0][2]))
    else $error("unbalanced lane word wrong");
  odd_red_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    ##2 red[0] == $past(hi_r[11:4]) && blu[0] == $past(lo_r[7:0]))
    else $error("odd pixel red or blue misrouted");
  even_green_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    ##2 grn[1] == {$past(hi_r[15:12]), $past(lo_r[23:20])})
    else $error("even pixel green misrouted");
  de_blank_pat_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    balance_s && pol_s && !de |=>
      lane_q[8] == `PAT_DEL_P || lane_q[8] == `PAT_DEL_N)
    else $error("data enable blanking pattern wrong");
  // High enable is blanking here, so it must take the low patterns
  de_swap_pat_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    balance_s && !pol_s && de |=>
      lane_q[8] == `PAT_DEL_P || lane_q[8] == `PAT_DEL_N)
    else $error("data enable polarity swap missing");
  hsync_pat_a: assert property (
    @(posedge pix_clk) disable iff (!arst_n)
    blank && hs |=>
      lane_q[0] == `PAT_SYH_P || lane_q[0] == `PAT_SYH_N)
    else $error("horizontal sync pattern wrong");
endmodule

// ---- core/pixel_tx_defines.svh ----
`ifndef PIXEL_TX_DEFINES_SVH
`define PIXEL_TX_DEFINES_SVH

`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04

`define CTRL_W 4
`define DUAL_BIT 0
`define BALANCE_BIT 1
`define CLKSEL_BIT 2
`define POL_BIT 3
`define CTRL_RST 4'h8

`define STAT_W 4
`define ST_ACT_BIT 0
`define ST_HS_BIT 1
`define ST_VS_BIT 2
`define ST_DUAL_BIT 3

`define PAT_CLK 7'h63
`define PAT_DEH_P 7'h78
`define PAT_DEH_N 7'h70
`define PAT_DEL_P 7'h7c
`define PAT_DEL_N 7'h60
`define PAT_SYH_P 7'h7c
`define PAT_SYH_N 7'h60
`define PAT_SYL_P 7'h78
`define PAT_SYL_N 7'h70

`endif

// ---- core/pixel_tx_pkg.sv ----
package pixel_tx_pkg;
  typedef logic [6:0] lane_word_t;
  typedef logic signed [4:0] disp_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage

// ---- core/bit_sync.sv ----
module bit_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  if (W < 1) begin : g_bad_w
    $error("bit_sync: W must be at least 1");
  end

  logic [W-1:0] meta_r;

  // Bits cross independently; only slow static levels go through here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- core/lane_balancer.sv ----
module lane_balancer (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     lane_on,
  input  wire logic                     dc_en,
  input  wire logic                     ctl_mode,
  input  wire pixel_tx_pkg::lane_word_t raw,
  input  wire logic [5:0]               pay,
  input  wire pixel_tx_pkg::lane_word_t pat_p,
  input  wire pixel_tx_pkg::lane_word_t pat_n,
  output pixel_tx_pkg::lane_word_t      word_q
);
  function automatic pixel_tx_pkg::disp_t disp(
    pixel_tx_pkg::lane_word_t w);
    int n;
    n = 0;
    for (int i = 0; i < 7; i++) n += int'(w[i]);
    return pixel_tx_pkg::disp_t'(2 * n - 7);
  endfunction

  pixel_tx_pkg::disp_t      rd_r;
  pixel_tx_pkg::disp_t      rd_nxt;
  pixel_tx_pkg::lane_word_t dat_a;
  pixel_tx_pkg::lane_word_t dat_b;
  pixel_tx_pkg::lane_word_t hi_w;
  pixel_tx_pkg::lane_word_t lo_w;
  pixel_tx_pkg::lane_word_t pick_w;
  pixel_tx_pkg::lane_word_t word_nxt;

  // Flag bit in front: the two candidates always have opposite disparity
  assign dat_a    = {1'b0, pay};
  assign dat_b    = {1'b1, ~pay};
  assign hi_w     = ctl_mode ? pat_p : (disp(dat_a) > 0 ? dat_a : dat_b);
  assign lo_w     = ctl_mode ? pat_n : (disp(dat_a) > 0 ? dat_b : dat_a);
  assign pick_w   = (rd_r > 0) ? lo_w : hi_w;
  assign word_nxt = !lane_on ? '0 : (dc_en ? pick_w : raw);
  assign rd_nxt   = (lane_on && dc_en) ? rd_r + disp(pick_w) : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_q <= '0;
      rd_r   <= '0;
    end else begin
      word_q <= word_nxt;
      rd_r   <= rd_nxt;
    end
  end

  disp_bound_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rd_r >= -7 && rd_r <= 7)
    else $error("running disparity out of range");

  disp_pull_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    lane_on && dc_en && rd_r > 0 |=> rd_r < $past(rd_r))
    else $error("positive disparity not pulled down");
endmodule

// ---- bench/pix_host_model.sv ----
module pix_host_model (
  output logic             pix_clk,
  output logic [23:0]      half_pixel_inputs,
  output logic             de_in,
  output logic             hsync_in,
  output logic             vsync_in,
  input  wire logic [23:0] lo_w,
  input  wire logic [23:0] hi_w,
  input  wire logic        de_w,
  input  wire logic        hs_w,
  input  wire logic        vs_w
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pixel clock runs free; odd offset keeps it off the register clock
  initial begin
    pix_clk = 1'b0;
    half_pixel_inputs = 24'h000000;
    de_in = 1'b0;
    hsync_in = 1'b0;
    vsync_in = 1'b0;
    #1.1;
    forever #3 pix_clk = ~pix_clk;
  end

  // Lower half set up a half period before the rising edge takes it
  always @(negedge pix_clk) begin
    half_pixel_inputs <= lo_w;
    de_in <= de_w;
    hsync_in <= hs_w;
    vsync_in <= vs_w;
  end

  always @(posedge pix_clk) begin
    half_pixel_inputs <= hi_w;
  end
endmodule

// ---- bench/tb.sv ----
`include "pixel_tx_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic            ref_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [7:0]      s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]      s_axi_wstrb = 4'hf;
  logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic            s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic            s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic            s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]      s_axi_bresp, s_axi_rresp, resp;
  logic            pix_clk, de_in, hsync_in, vsync_in, diff_clock_select;
  logic            de_w = 1'b0, hs_w = 1'b0, vs_w = 1'b0;
  logic [23:0]     half_pixel_inputs;
  logic [23:0]     lo_w = 24'h369c96, hi_w = 24'h5aca53;
  logic [7:0][6:0] serial_data_lanes;
  logic [6:0]      first_clock_lane, second_clock_lane;
  logic [9:0]      lane_enable;
  logic [31:0]     rd;
  int              n_errors = 0, num_checks = 0, cycles = 0;
  // Red, green, blue of pixel 1 then pixel 2, matching lo_w and hi_w
  localparam logic [7:0] PX [6] = '{8'ha5, 8'h3c, 8'h96, 8'h5a, 8'hc3, 8'h69};

  always #2 ref_clk = ~ref_clk;

  pixel_tx_mapper u_dut (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pix_clk, .half_pixel_inputs, .de_in,
    .hsync_in, .vsync_in, .serial_data_lanes, .first_clock_lane,
    .second_clock_lane, .lane_enable, .diff_clock_select);

  pix_host_model u_host (.pix_clk, .half_pixel_inputs, .de_in, .hsync_in,
    .vsync_in, .lo_w, .hi_w, .de_w, .hs_w, .vs_w);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Covers a hung handshake; the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    resp = s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [7:0] lv(input logic [7:0] x);
    return {x[1], x[0], x[7:2]};
  endfunction

  // Unbalanced words {lane3, lane2, lane1, lane0} of port p
  function automatic logic [27:0] unb(input int p, input logic hs, vs, de);
    logic [7:0] r, g, b;
    r = lv(PX[3*p]);
    g = lv(PX[3*p+1]);
    b = lv(PX[3*p+2]);
    return {{r[6], r[7], g[6], g[7], b[6], b[7], 1'b0},
            {b[2], b[3], b[4], b[5], hs, vs, de},
            {g[1], g[2], g[3], g[4], g[5], b[0], b[1]},
            {r[0], r[1], r[2], r[3], r[4], r[5], g[0]}};
  endfunction

  function automatic logic [23:0] bpay(input int p);
    logic [7:0] r, g, b;
    r = lv(PX[3*p]);
    g = lv(PX[3*p+1]);
    b = lv(PX[3*p+2]);
    return {r[7], r[6], g[7], g[6], b[7], b[6], b[5:0], g[5:0], r[5:0]};
  endfunction

  function automatic logic inp(input logic [6:0] w, p, n);
    return w === p || w === n;
  endfunction

  // Control crosses to the link domain, so give it time to land
  task automatic settle(input logic [31:0] cfg, input logic de, hs, vs);
    axw(`CTRL_OFS, cfg);
    chk(resp, 2'h0);
    de_w <= de;
    hs_w <= hs;
    vs_w <= vs;
    repeat (12) @(negedge pix_clk);
  endtask

  task automatic t_regs();
    axr(`CTRL_OFS);
    chk(rd, 32'h8);
    axr(8'h08);
    chk(resp, 2'h2);
    chk(rd, 32'h0);
    axw(8'h08, 32'hf);
    chk(resp, 2'h2);
    axw(`STAT_OFS, 32'hf);
    chk(resp, 2'h0);
    s_axi_wstrb <= 4'h0;
    axw(`CTRL_OFS, 32'h7);
    chk(resp, 2'h0);
    s_axi_wstrb <= 4'hf;
    axr(`CTRL_OFS);
    chk(rd, 32'h8);
    $display("t_regs done");
  endtask

  task automatic t_diff_clock_select();
    axw(`CTRL_OFS, 32'hc);
    repeat (3) @(posedge ref_clk);
    chk(diff_clock_select, 1'b1);
    axw(`CTRL_OFS, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk(diff_clock_select, 1'b0);
    $display("t_diff_clock_select done");
  endtask

  task automatic t_unbal(input logic dual);
    settle({28'h0, 4'h8} | dual, 1'b1, 1'b0, 1'b1);
    chk(serial_data_lanes[3:0], unb(0, 0, 1, 1));
    chk(serial_data_lanes[7:4], dual ? unb(1, 0, 1, 1) : 28'h0);
    chk(lane_enable, dual ? 10'h3ff : 10'h10f);
    chk(first_clock_lane, `PAT_CLK);
    chk(second_clock_lane, dual ? `PAT_CLK : 7'h00);
    axr(`STAT_OFS);
    chk(rd, dual ? 32'hd : 32'h5);
    $display("t_unbal done");
  endtask

  task automatic t_blank();
    settle(32'hb, 1'b0, 1'b1, 1'b0);
    chk(inp(first_clock_lane, `PAT_DEL_P, `PAT_DEL_N), 1'b1);
    chk(inp(second_clock_lane, `PAT_DEL_P, `PAT_DEL_N), 1'b1);
    chk(inp(serial_data_lanes[0], `PAT_SYH_P, `PAT_SYH_N), 1'b1);
    chk(inp(serial_data_lanes[1], `PAT_SYL_P, `PAT_SYL_N), 1'b1);
    settle(32'h3, 1'b1, 1'b0, 1'b1);
    chk(inp(first_clock_lane, `PAT_DEL_P, `PAT_DEL_N), 1'b1);
    chk(inp(serial_data_lanes[0], `PAT_SYL_P, `PAT_SYL_N), 1'b1);
    chk(inp(serial_data_lanes[1], `PAT_SYH_P, `PAT_SYH_N), 1'b1);
    $display("t_blank done");
  endtask

  task automatic t_dc_active();
    int d;
    logic [5:0] pay;
    logic [6:0] w;
    d = 0;
    settle(32'hb, 1'b1, 1'b0, 1'b0);
    repeat (8) begin
      for (int i = 0; i < 8; i++) begin
        w = serial_data_lanes[i];
        pay = 6'(bpay(i / 4) >> (6 * (i % 4)));
        chk(w[5:0] ^ {6{w[6]}}, pay);
      end
      d += 2 * $countones(serial_data_lanes[0]) - 7;
      chk(d inside {[-14:14]}, 1'b1);
      chk(first_clock_lane, `PAT_CLK);
      @(negedge pix_clk);
    end
    $display("t_dc_active done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_diff_clock_select();
    t_unbal(1'b0);
    t_unbal(1'b1);
    t_blank();
    t_dc_active();
    complete_run();
  end
endmodule
